// *** core/eeprom_loader_pkg.sv ***
// constants, types and address map for the serial EEPROM loader
package eeprom_loader_pkg;

  // core clock and serial clock timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_PERIOD_NS = 800;
  localparam logic [2:0] SCK_HALF_LAST = 3'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS) - 1);

  // serial EEPROM opcodes and frame lengths in bits
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [5:0] NBITS_RW   = 6'h28;
  localparam logic [5:0] NBITS_WREN = 6'h08;
  localparam logic [5:0] NBITS_RDSR = 6'h10;
  localparam int         RDSR_WIP_BIT = 0;

  // load image layout, word addresses and byte offsets in the EEPROM
  localparam logic [15:0] SIGNATURE        = 16'h1516;
  localparam logic [7:0]  SIG_WORD         = 8'h00;
  localparam logic [7:0]  FIRST_LOAD_WORD  = 8'h01;
  localparam logic [7:0]  SHARED_FIRST_OFS = 8'h02;
  localparam logic [7:0]  SHARED_LAST_OFS  = 8'h1E;
  localparam logic [7:0]  PORT_FIRST_OFS   = 8'h20;
  localparam logic [7:0]  PORT_LAST_OFS    = 8'h8A;
  localparam logic [3:0]  PORT_SLOT_LAST   = 4'hA;
  localparam logic [7:0]  LOAD_LAST_OFS    = 8'h8A;

  // register byte offsets and fields
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_RDATA     = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] REG_STATUS    = 8'hA0;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SIG_BIT   = 1;
  localparam int STAT_DONE_BIT  = 4;
  localparam int IRQ_ACCESS_BIT = 0;
  localparam int IRQ_LOAD_BIT   = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // byte enables towards the configuration registers
  localparam logic [1:0] BE_BOTH = 2'h3;
  localparam logic [1:0] BE_LOW  = 2'h1;

  typedef enum logic [2:0] {
    GRP_SHARED  = 3'h0,
    GRP_LINK    = 3'h1,
    GRP_PHY_HI  = 3'h2,
    GRP_LANE    = 3'h3,
    GRP_PM      = 3'h4,
    GRP_SLOT    = 3'h5,
    GRP_BUDGET  = 3'h6,
    GRP_PM_CTRL = 3'h7
  } cfg_group_e;

  typedef struct packed {
    logic       valid;
    cfg_group_e group;
    logic [2:0] port;
    logic [3:0] index;
    logic [1:0] be;
  } cfg_target_s;

  typedef enum logic [7:0] {
    ST_BOOT = 8'h01,
    ST_SIG  = 8'h02,
    ST_LOAD = 8'h04,
    ST_IDLE = 8'h08,
    ST_RD   = 8'h10,
    ST_WREN = 8'h20,
    ST_WR   = 8'h40,
    ST_POLL = 8'h80
  } loader_state_e;

endpackage

// *** core/spi_word_if.sv ***
// frame request and answer between loader sequencer and serial engine
`timescale 1ns/1ps
`default_nettype none
interface spi_word_if;
  logic        start;
  logic [5:0]  nbits;
  logic [39:0] txd;
  logic        busy;
  logic        done;
  logic [15:0] rxd;

  modport ctrl   (output start, output nbits, output txd, input busy, input done, input rxd);
  modport engine (input start, input nbits, input txd, output busy, output done, output rxd);
endinterface
`default_nettype wire

// *** core/spi_word_engine.sv ***
// serial EEPROM frame engine: mode 0, msb first, clock divided from core clock
`timescale 1ns/1ps
`default_nettype none
module spi_word_engine
  import eeprom_loader_pkg::*;
(
  input  wire logic clk_i,      // core clock
  input  wire logic rst_n_i,    // synchronised reset, active low
  spi_word_if.engine frame,      // frame request and answer
  input  wire logic miso_i,     // data from the EEPROM, asynchronous
  output logic      sck_o,      // serial clock
  output logic      cs_n_o,     // chip select, active low
  output logic      mosi_o      // data towards the EEPROM
);

  logic        miso_meta;
  logic        miso_sync;
  logic        active;
  logic        done;
  logic [2:0]  div;
  logic [5:0]  bits;
  logic [39:0] sh;
  logic [15:0] rx;

  // data-out line comes from another timing domain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end else begin
      miso_meta <= miso_i;
      miso_sync <= miso_meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active <= 1'b0;
      done   <= 1'b0;
      sck_o  <= 1'b0;
      cs_n_o <= 1'b1;
      div    <= 3'h0;
      bits   <= 6'h00;
      sh     <= 40'h0;
      rx     <= 16'h0;
    end else begin
      done <= 1'b0;
      if (!active) begin
        if (frame.start) begin
          active <= 1'b1;
          cs_n_o <= 1'b0;
          sh     <= frame.txd;
          bits   <= frame.nbits;
          div    <= 3'h0;
        end
      end else if (div == SCK_HALF_LAST) begin
        div <= 3'h0;
        if (sck_o) begin
          sck_o <= 1'b0;
          sh    <= {sh[38:0], 1'b0};
          bits  <= bits - 6'h01;
        end else if (bits == 6'h00) begin
          // last low half elapsed: release select, keeps hold time
          active <= 1'b0;
          cs_n_o <= 1'b1;
          done   <= 1'b1;
        end else begin
          sck_o <= 1'b1;
          rx    <= {rx[14:0], miso_sync};
        end
      end else begin
        div <= div + 3'h1;
      end
    end
  end

  assign mosi_o     = sh[39];
  assign frame.busy = active;
  assign frame.done = done;
  assign frame.rxd  = rx;

endmodule // spi_word_engine
`default_nettype wire

// *** core/serial_eeprom_autoloader.sv ***
// serial EEPROM loader: signature check, autoload, software word access, register slave
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_autoloader
  import eeprom_loader_pkg::*;
(
  input  wire logic        core_clk_i,            // core clock, 10 MHz
  input  wire logic        rstn_i,                // reset, active low, asynchronous
  input  wire logic [7:0]  avs_address_i,         // register byte address
  input  wire logic        avs_read_i,            // read request
  input  wire logic        avs_write_i,           // write request
  input  wire logic [31:0] avs_writedata_i,       // write data
  input  wire logic [3:0]  avs_byteenable_i,      // write byte lanes
  output logic      [31:0] avs_readdata_o,        // read data
  output logic             avs_waitrequest_o,     // stall while the answer is pending
  output logic             irq_o,                 // level interrupt
  output logic             eeprom_serial_clock_o, // EEPROM serial clock
  output logic             eeprom_select_out_n_o, // EEPROM chip select, active low
  output logic             eeprom_serial_in_o,    // data into the EEPROM
  input  wire logic        eeprom_serial_out_i,   // data out of the EEPROM
  output logic             cfg_wr_o,              // loaded word write strobe
  output cfg_group_e       cfg_group_o,           // target register group
  output logic      [2:0]  cfg_port_o,            // target port
  output logic      [3:0]  cfg_index_o,           // word index in shared group
  output logic      [1:0]  cfg_byte_en_o,         // bytes of cfg_data_o to write
  output logic      [15:0] cfg_data_o,            // loaded word
  output logic             autoload_done_o        // load finished, host may access
);

  logic [1:0]    rst_pipe;
  logic          rst_n;
  loader_state_e state;
  spi_word_if    frame ();
  logic          go;
  logic [5:0]    go_nbits;
  logic [39:0]   go_txd;
  logic [7:0]    ld_word;
  logic          sig_ok;
  logic          load_done;
  logic          ctl_write;
  logic [7:0]    ctl_addr;
  logic [15:0]   ctl_wdata;
  logic [15:0]   rd_data;
  logic          start_pend;
  logic          ack;
  logic [1:0]    irq_stat;
  logic [1:0]    irq_mask;
  logic [1:0]    irq_evt;
  logic          access_evt;
  logic          bus_req;
  logic          wr_acc;
  logic [15:0]   rx_word;
  logic [7:0]    ld_ofs;
  cfg_target_s   tgt;

  // async assert, release through two flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  spi_word_engine engine (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .frame   (frame.engine),
    .miso_i  (eeprom_serial_out_i),
    .sck_o   (eeprom_serial_clock_o),
    .cs_n_o  (eeprom_select_out_n_o),
    .mosi_o  (eeprom_serial_in_o)
  );

  assign frame.start = go;
  assign frame.nbits = go_nbits;
  assign frame.txd   = go_txd;

  // first received byte is the low byte of the word
  assign rx_word = {frame.rxd[7:0], frame.rxd[15:8]};
  assign ld_ofs  = {ld_word[6:0], 1'b0};

  // where each image word lands in configuration space
  function automatic cfg_target_s map_word(input logic [7:0] ofs);
    cfg_target_s t;
    t.valid = 1'b0;
    t.group = GRP_SHARED;
    t.port  = 3'h0;
    t.index = 4'h0;
    t.be    = BE_BOTH;
    if (ofs >= SHARED_FIRST_OFS && ofs <= SHARED_LAST_OFS) begin
      t.valid = 1'b1;
      t.index = ofs[4:1];
    // per-port groups, 16 bytes apart, six ports each
    end else if (ofs >= PORT_FIRST_OFS && ofs <= PORT_LAST_OFS && ofs[3:0] <= PORT_SLOT_LAST) begin
      t.valid = 1'b1;
      t.group = cfg_group_e'(3'(ofs[7:4] - 4'h1));
      t.port  = ofs[3:1];
      t.be    = (t.group == GRP_PM_CTRL) ? BE_LOW : BE_BOTH;
    end
    return t;
  endfunction

  assign tgt = map_word(ld_ofs);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_BOOT;
      go         <= 1'b0;
      go_nbits   <= 6'h00;
      go_txd     <= 40'h0;
      ld_word    <= SIG_WORD;
      sig_ok     <= 1'b0;
      load_done  <= 1'b0;
      rd_data    <= 16'h0;
      access_evt <= 1'b0;
    end else begin
      go         <= 1'b0;
      access_evt <= 1'b0;
      if (state == ST_IDLE) load_done <= 1'b1;
      unique case (state)
        // fetch the signature without software help
        ST_BOOT: begin
          go       <= 1'b1;
          go_nbits <= NBITS_RW;
          // byte address is twice the word address
          go_txd   <= {OP_READ, 7'h00, SIG_WORD, 1'b0, 16'h0};
          state    <= ST_SIG;
        end
        ST_SIG: if (frame.done) begin
          if (rx_word == SIGNATURE) begin
            sig_ok   <= 1'b1;
            ld_word  <= FIRST_LOAD_WORD;
            go       <= 1'b1;
            go_nbits <= NBITS_RW;
            go_txd   <= {OP_READ, 7'h00, FIRST_LOAD_WORD, 1'b0, 16'h0};
            state    <= ST_LOAD;
          end else begin
            // skip the load, open host access
            load_done <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        ST_LOAD: if (frame.done) begin
          // last word; done follows in idle, after its write
          if (ld_ofs == LOAD_LAST_OFS) begin
            state     <= ST_IDLE;
          end else begin
            ld_word  <= ld_word + 8'h01;
            go       <= 1'b1;
            go_nbits <= NBITS_RW;
            go_txd   <= {OP_READ, 7'h00, 8'(ld_word + 8'h01), 1'b0, 16'h0};
          end
        end
        // a start outside idle is dropped
        ST_IDLE: if (start_pend) begin
          go <= 1'b1;
          if (ctl_write) begin
            go_nbits <= NBITS_WREN;
            go_txd   <= {OP_WREN, 32'h0};
            state    <= ST_WREN;
          end else begin
            go_nbits <= NBITS_RW;
            go_txd   <= {OP_READ, 7'h00, ctl_addr, 1'b0, 16'h0};
            state    <= ST_RD;
          end
        end
        ST_RD: if (frame.done) begin
          rd_data    <= rx_word;
          access_evt <= 1'b1;
          state      <= ST_IDLE;
        end
        ST_WREN: if (frame.done) begin
          go       <= 1'b1;
          go_nbits <= NBITS_RW;
          go_txd   <= {OP_WRITE, 7'h00, ctl_addr, 1'b0, ctl_wdata[7:0], ctl_wdata[15:8]};
          state    <= ST_WR;
        end
        ST_WR: if (frame.done) begin
          go       <= 1'b1;
          go_nbits <= NBITS_RDSR;
          go_txd   <= {OP_RDSR, 32'h0};
          state    <= ST_POLL;
        end
        // poll until the internal write cycle ends
        ST_POLL: if (frame.done) begin
          if (frame.rxd[RDSR_WIP_BIT]) begin
            go       <= 1'b1;
            go_nbits <= NBITS_RDSR;
            go_txd   <= {OP_RDSR, 32'h0};
          end else begin
            access_evt <= 1'b1;
            state      <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wr_o      <= 1'b0;
      cfg_group_o   <= GRP_SHARED;
      cfg_port_o    <= 3'h0;
      cfg_index_o   <= 4'h0;
      cfg_byte_en_o <= 2'h0;
      cfg_data_o    <= 16'h0;
    end else begin
      cfg_wr_o <= (state == ST_LOAD) && frame.done && tgt.valid;
      if ((state == ST_LOAD) && frame.done) begin
        cfg_group_o   <= tgt.group;
        cfg_port_o    <= tgt.port;
        cfg_index_o   <= tgt.index;
        cfg_byte_en_o <= tgt.be;
        // low and high bytes as stored
        cfg_data_o    <= rx_word;
      end
    end
  end

  assign autoload_done_o = load_done;

  // bus slave: answer one cycle after the request is seen
  assign bus_req           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack;
  assign wr_acc            = avs_write_i & ack;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack <= bus_req & ~ack;
      if (avs_read_i && !ack) begin
        unique case (avs_address_i)
          REG_CTRL:     avs_readdata_o <= {ctl_wdata, ctl_addr, 6'h00, ctl_write, 1'b0};
          REG_RDATA:    avs_readdata_o <= {16'h0, rd_data};
          REG_IRQ_STAT: avs_readdata_o <= {30'h0, irq_stat};
          REG_IRQ_MASK: avs_readdata_o <= {30'h0, irq_mask};
          REG_STATUS:   avs_readdata_o <= {27'h0, load_done, 2'h0, sig_ok, state != ST_IDLE};
          default:      avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_write  <= 1'b0;
      ctl_addr   <= 8'h00;
      ctl_wdata  <= 16'h0;
      start_pend <= 1'b0;
    end else begin
      start_pend <= 1'b0;
      if (wr_acc && avs_address_i == REG_CTRL) begin
        if (avs_byteenable_i[0]) begin
          ctl_write  <= avs_writedata_i[CTRL_WRITE_BIT];
          start_pend <= avs_writedata_i[CTRL_START_BIT];
        end
        if (avs_byteenable_i[1]) ctl_addr <= avs_writedata_i[15:8];
        if (avs_byteenable_i[2]) ctl_wdata[7:0] <= avs_writedata_i[23:16];
        if (avs_byteenable_i[3]) ctl_wdata[15:8] <= avs_writedata_i[31:24];
      end
    end
  end

  // sticky events; a new event beats a same-cycle clear
  assign irq_evt = {(state == ST_LOAD || state == ST_SIG) && frame.done && load_done == 1'b0
                    && (ld_ofs == LOAD_LAST_OFS || (state == ST_SIG && rx_word != SIGNATURE)),
                    access_evt};

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      if (wr_acc && avs_address_i == REG_IRQ_STAT && avs_byteenable_i[0]) begin
        irq_stat <= (irq_stat & ~avs_writedata_i[1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      if (wr_acc && avs_address_i == REG_IRQ_MASK && avs_byteenable_i[0]) begin
        irq_mask <= avs_writedata_i[1:0];
      end
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

endmodule // serial_eeprom_autoloader
`default_nettype wire

// *** sim/serial_eeprom_autoloader_props.sv ***
// port-level assertions for the serial EEPROM loader
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_autoloader_props
  import eeprom_loader_pkg::*;
(
  input wire logic        core_clk_i,            // core clock
  input wire logic        rstn_i,                // reset, active low
  input wire logic [7:0]  avs_address_i,         // bus address
  input wire logic        avs_read_i,            // bus read
  input wire logic        avs_write_i,           // bus write
  input wire logic [31:0] avs_readdata_o,        // bus read data
  input wire logic        avs_waitrequest_o,     // bus stall
  input wire logic        eeprom_serial_clock_o, // serial clock
  input wire logic        eeprom_select_out_n_o, // select, active low
  input wire logic        eeprom_serial_in_o,    // data to EEPROM
  input wire logic        cfg_wr_o,              // load strobe
  input wire cfg_group_e  cfg_group_o,           // load group
  input wire logic [2:0]  cfg_port_o,            // load port
  input wire logic [1:0]  cfg_byte_en_o,         // load lanes
  input wire logic        autoload_done_o        // load finished
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_wait_once: assert property (
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after exactly one wait cycle");
  chk_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o && !(avs_address_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'hA0})
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_boot_go: assert property (
    $rose(rstn_i) |-> ##[1:8] !eeprom_select_out_n_o)
    else $error("no boot frame after reset");
  chk_sck_high4: assert property (
    $rose(eeprom_serial_clock_o) |-> eeprom_serial_clock_o [*4] ##1 !eeprom_serial_clock_o)
    else $error("serial clock high phase wrong");
  chk_sck_idle: assert property (
    eeprom_select_out_n_o |-> !eeprom_serial_clock_o)
    else $error("serial clock runs while deselected");
  chk_mosi_hold: assert property (
    eeprom_serial_clock_o && $past(eeprom_serial_clock_o) |-> $stable(eeprom_serial_in_o))
    else $error("data changed while serial clock high");
  chk_done_holds: assert property (
    autoload_done_o |=> autoload_done_o)
    else $error("done flag dropped");
  chk_wr_single: assert property (
    cfg_wr_o |=> !cfg_wr_o)
    else $error("load strobe longer than one cycle");
  chk_wr_before_done: assert property (
    cfg_wr_o |-> !autoload_done_o)
    else $error("load write after done");
  chk_lane_group: assert property (
    cfg_wr_o |-> cfg_byte_en_o == ((cfg_group_o == GRP_PM_CTRL) ? BE_LOW : BE_BOTH))
    else $error("byte lanes do not suit group");
  chk_port_range: assert property (
    cfg_wr_o && cfg_group_o != GRP_SHARED |-> cfg_port_o <= 3'h5)
    else $error("port out of range");
endmodule // serial_eeprom_autoloader_props

bind serial_eeprom_autoloader serial_eeprom_autoloader_props props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .eeprom_serial_clock_o(eeprom_serial_clock_o),
  .eeprom_select_out_n_o(eeprom_select_out_n_o), .eeprom_serial_in_o(eeprom_serial_in_o),
  .cfg_wr_o(cfg_wr_o), .cfg_group_o(cfg_group_o), .cfg_port_o(cfg_port_o),
  .cfg_byte_en_o(cfg_byte_en_o), .autoload_done_o(autoload_done_o));
`default_nettype wire

// *** sim/spi_eeprom_model.sv ***
// behavioural serial EEPROM of 16-bit words, clock mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_model
  import eeprom_loader_pkg::*;
(
  input  wire logic sck_i,  // serial clock
  input  wire logic cs_n_i, // select, active low
  input  wire logic mosi_i, // data in
  output var  logic miso_o  // data out
);
  logic [15:0] mem [0:255];
  logic [7:0]  op;
  logic [15:0] adr;
  logic [15:0] din;
  logic [15:0] word;
  logic        wel = 1'b0;
  int          cnt = 0;
  int          busy_left = 0;

  initial miso_o = 1'b0;
  always @(negedge cs_n_i) cnt = 0;
  always @(posedge sck_i) if (!cs_n_i) begin
    if (cnt < 8) op = {op[6:0], mosi_i};
    else if (cnt < 24) adr = {adr[14:0], mosi_i};
    else din = {din[14:0], mosi_i};
    cnt++;
  end
  // word at byte address/2, low byte first
  always @(negedge sck_i) if (!cs_n_i) begin
    word = mem[adr[8:1]];
    if (op == OP_READ && cnt >= 24) miso_o = (cnt < 32) ? word[31-cnt] : word[47-cnt];
    if (op == OP_RDSR && cnt >= 8) miso_o = (cnt == 15) && (busy_left > 0);
  end
  // released line shows the inverse, never a stale bit; write stays busy two polls
  always @(posedge cs_n_i) begin
    miso_o = ~miso_o;
    if (op == OP_WREN) wel = 1'b1;
    if (op == OP_RDSR && busy_left > 0) busy_left--;
    if (op == OP_WRITE && wel) begin
      mem[adr[8:1]] = {din[7:0], din[15:8]};
      wel = 1'b0;
      busy_left = 2;
    end
  end
endmodule // spi_eeprom_model
`default_nettype wire

// *** sim/tb_serial_eeprom_autoloader.sv ***
// self-checking bench for the serial EEPROM loader
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_autoloader
  import eeprom_loader_pkg::*;
;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, waitreq, irq, sck, cs_n, mosi, miso, cfg_wr, done;
  logic [7:0]  adr = 0, eofs = 8'h02;
  logic [31:0] wdat = 0, rdat, v;
  logic [3:0]  lanes = 4'hF, idx;
  logic [2:0]  port, eg;
  logic [1:0]  be;
  logic [15:0] cdat;
  cfg_group_e  grp;
  int          miscompares = 0, samples_checked = 0, cycles = 0, wr_seen = 0;

  always #50 clk = ~clk;

  serial_eeprom_autoloader uut (.core_clk_i(clk), .rstn_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(lanes),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .irq_o(irq),
    .eeprom_serial_clock_o(sck), .eeprom_select_out_n_o(cs_n), .eeprom_serial_in_o(mosi),
    .eeprom_serial_out_i(miso), .cfg_wr_o(cfg_wr), .cfg_group_o(grp), .cfg_port_o(port),
    .cfg_index_o(idx), .cfg_byte_en_o(be), .cfg_data_o(cdat), .autoload_done_o(done));
  spi_eeprom_model mdl (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso));

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // next mapped byte offset; reserved tails of each per-port row skipped
  function automatic logic [7:0] next_ofs(input logic [7:0] o);
    next_ofs = o + 8'h02;
    if (next_ofs >= 8'h20 && next_ofs[3:0] >= 4'hC) next_ofs = {next_ofs[7:4] + 4'h1, 4'h0};
  endfunction

  always @(posedge clk) if (rst_n && cfg_wr === 1'b1) begin
    wr_seen++;
    eg = (eofs < 8'h20) ? 3'h0 : 3'(eofs[7:4] - 4'h1);
    check(32'(eg), 32'(grp));
    if (eofs < 8'h20) check(32'(eofs[4:1]), 32'(idx));
    else check(32'(eofs[3:1]), 32'(port));
    check(32'((eg == 3'h7) ? BE_LOW : BE_BOTH), 32'(be));
    check(32'(mdl.mem[eofs[7:1]]), 32'(cdat));
    eofs = next_ofs(eofs);
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(e, q & m);
  endtask

  // host writes the start, then polls status until the busy bit clears
  task automatic seq(input logic [31:0] ctrl);
    bus(1'b1, REG_CTRL, ctrl, v);
    for (int i = 0; i < 2000; i++) begin
      bus(1'b0, REG_STATUS, 32'h0, v);
      if (v[STAT_BUSY_BIT] === 1'b0) break;
    end
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wait_done;
    for (int i = 0; i < 30000 && done !== 1'b1; i++) @(posedge clk);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mdl.mem[i] = {8'(i) ^ 8'h5A, 8'(i)};
    mdl.mem[0] = SIGNATURE;
    do_reset();
    check(32'h0, 32'(done));
    wait_done();
    check(32'h1, 32'(done));
    check(32'd57, 32'(wr_seen));
    check(32'h90, 32'(eofs));
    rd_chk(REG_STATUS, 32'h13, 32'h12);
    rd_chk(REG_IRQ_STAT, 32'h3, 32'h2);
    check(32'h0, 32'(irq));
    bus(1'b1, REG_IRQ_MASK, 32'h3, v);
    @(posedge clk);
    check(32'h1, 32'(irq));
    bus(1'b1, REG_IRQ_STAT, 32'h2, v);
    @(posedge clk);
    check(32'h0, 32'(irq));
    rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0);
    seq({16'hBEEF, 8'h30, 8'h03});
    check(32'hBEEF, 32'(mdl.mem[8'h30]));
    rd_chk(REG_IRQ_STAT, 32'h3, 32'h1);
    bus(1'b1, REG_IRQ_STAT, 32'h1, v);
    seq({16'h0, 8'h30, 8'h01});
    rd_chk(REG_RDATA, 32'hFFFF, 32'hBEEF);
    seq({16'h0, 8'hFF, 8'h01});
    rd_chk(REG_RDATA, 32'hFFFF, 32'hA5FF);
    bus(1'b1, REG_CTRL, {16'h0, 8'h10, 8'h01}, v);
    rd_chk(REG_STATUS, 32'h1, 32'h1);
    seq({16'h0, 8'h11, 8'h01});
    rd_chk(REG_RDATA, 32'hFFFF, 32'h4A10);
    mdl.mem[0] = SIGNATURE ^ 16'h0001;
    wr_seen = 0;
    do_reset();
    wait_done();
    check(32'h0, 32'(wr_seen));
    rd_chk(REG_STATUS, 32'h13, 32'h10);
    rd_chk(REG_IRQ_MASK, 32'h3, 32'h0);
    tally_and_finish();
  end
endmodule // tb_serial_eeprom_autoloader
`default_nettype wire
